// file: hdl/coid_map.svh
`ifndef COID_MAP_SVH
`define COID_MAP_SVH
// register offsets (byte addresses, one word each)
`define COID_OFS_FEATURE   8'h00
`define COID_OFS_COUNT     8'h04
`define COID_OFS_ADDR_LOW  8'h08
`define COID_OFS_ADDR_MID  8'h0c
`define COID_OFS_ADDR_HIGH 8'h10
`define COID_OFS_DRIVE     8'h14
`define COID_OFS_COMMAND   8'h18
`define COID_OFS_ERROR     8'h1c
`define COID_OFS_STATE     8'h20
`define COID_OFS_DATA      8'h24
`define COID_OFS_CTRL      8'h28
`define COID_OFS_WORD63    8'h2c
`define COID_OFS_WORD88    8'h30
`define COID_OFS_WORD82    8'h34
`define COID_OFS_WORD83    8'h38
`define COID_OFS_WORD84    8'h3c
`define COID_OFS_MAXLBA_LO 8'h40
`define COID_OFS_MAXLBA_HI 8'h44
// command codes
`define COID_CMD_OVERLAY   8'hb1
`define COID_FEAT_FREEZE   8'hc1
`define COID_FEAT_IDENTIFY 8'hc2
`define COID_FEAT_SET      8'hc3
// structure constants
`define COID_REVISION      16'h0002
`define COID_SIGNATURE     8'ha5
`define COID_LAST_WORD     8'hff
`define COID_W7_ALLOWED    16'h3bff
`define COID_W1_MASK       16'h0007
`define COID_W2_MASK       16'h007f
// state, error and drive register bit positions
`define COID_ST_BUSY       7
`define COID_ST_READY      6
`define COID_ST_FAULT      5
`define COID_ST_XFER       3
`define COID_ST_ERR        0
`define COID_ERR_ABORT     2
`define COID_DRV_BIT       4
// abort word codes
`define COID_WORD_REV      8'h00
`define COID_WORD_LBA      8'h03
`define COID_WORD_CSUM     8'hff
// factory defaults
`define COID_DEF_W63       16'h0007
`define COID_DEF_W88       16'h007f
`define COID_DEF_W82       16'h0400
`define COID_DEF_W83       16'h0560
`define COID_DEF_W84       16'h06d0
`define COID_DEF_MAXLBA    48'h0000_0fff_ffff
`endif

// file: hdl/coid_pkg.sv
package coid_pkg;
   // command engine states, one-hot
   typedef enum logic [3:0] {
      COID_IDLE = 4'b0001,
      COID_SEND = 4'b0010,
      COID_RECV = 4'b0100,
      COID_DONE = 4'b1000
   } coid_state_t;
endpackage

// file: hdl/coid_top.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "coid_map.svh"
module coid_top (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // power-on reset, clears freeze lock only
   input  wire logic                 por_i,
   // device inputs
   input  wire logic                 standby_jumper_i,
   input  wire logic                 hpa_established_i,
   input  wire logic [15:0]          dma_selected_i,
   // avalon-mm slave
   input  wire logic [7:0]           avs_address_i,
   input  wire logic                 avs_read_i,
   input  wire logic                 avs_write_i,
   input  wire logic [31:0]          avs_writedata_i,
   input  wire logic [3:0]           avs_byteenable_i,
   output logic      [31:0]          avs_readdata_o,
   output logic                      avs_waitrequest_o,
   // command state
   output coid_pkg::coid_state_t     state_o,
   output logic                      freeze_lock_o
);
   import coid_pkg::*;

   // overview of the datapath:
   // - the task-file registers, the identify words and the overlay capture all live in one struct
   // - a single combinational process works out the next struct from bus traffic and engine state
   // - one clocked process registers it, so every output below except avs_waitrequest_o comes from a flip-flop
   // - the freeze lock sits outside the struct because it has its own reset source
   // - identify words are built on the fly from live state; no 512-byte buffer is kept
   // - the overlay is not stored either: only words 0-5, 7 and 255 matter, the rest is summed
   // - the trade-off: a second identify after a set shows the reduced words, not a snapshot

   // all module state except the freeze lock
   typedef struct packed {
      coid_state_t st;           // engine state
      logic [7:0]  feat;         // feature_select
      logic [7:0]  count;        // block_count_or_vendor_info
      logic [7:0]  alo;          // address_byte_low
      logic [7:0]  amid;         // address_byte_mid
      logic [7:0]  ahi;          // address_byte_high
      logic [7:0]  drv;          // drive_select
      logic [7:0]  err;          // error_flags
      logic [7:0]  dst;          // device_state
      logic [7:0]  widx;         // word index in transfer
      logic [7:0]  csum;         // running byte sum
      logic        ack;          // bus answer pending
      logic [31:0] rdata;        // read data
      logic        modified;     // overlay already applied
      logic [15:0] w63;          // identify word 63
      logic [15:0] w82;
      logic [15:0] w83;
      logic [15:0] w84;
      logic [15:0] w88;
      logic [47:0] maxlba;       // native maximum address
      logic [15:0] rx_w1;        // captured overlay words
      logic [15:0] rx_w2;
      logic [15:0] rx_w7;
      logic [47:0] rx_lba;
      logic        rx_revbad;
      logic        rx_rsvbad;    // signature byte wrong
   } coid_s_t;

   coid_s_t     s_r;             // registered state
   coid_s_t     s_nxt;           // next state
   logic        frz_r;           // freeze lock, power-on only
   logic        frz_nxt;
   logic [15:0] w7_cur;          // current word 7 permissions
   logic [15:0] tx_word;         // identify word being sent
   logic [15:0] rx_word;         // incoming overlay word
   logic        wr;              // accepted write
   logic        rd;              // accepted read
   logic [15:0] bad_bits;        // cleared bits that may not clear
   logic [7:0]  bad_word;        // first offending word

   // a write lands on the edge where waitrequest is seen low, i.e. the second edge of the
   // request; taking it on the first edge would act on a cycle the master has not finished
   // reads are launched on the first edge so the data already stands on the second
   assign wr = avs_write_i & s_r.ack;
   assign rd = avs_read_i & ~s_r.ack;
   assign rx_word = avs_writedata_i[15:0];
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_r.ack;
   assign avs_readdata_o = s_r.rdata;
   assign state_o = s_r.st;
   assign freeze_lock_o = frz_r;

   // word 7 derived from live identify words
   // only bits 4, 7 and 8 can drop after a set; the others stay permitted
   // because w7_cur reads no live identify word for them
   // limitation: bits 9 and 11 are cleared in word 84 but still reported as allowed,
   // since the structure shows what may be selected, not what is selected now
   always_comb begin
      w7_cur = `COID_W7_ALLOWED;   // bit 10 kept zero
      w7_cur[8] = s_r.w83[10];
      w7_cur[7] = s_r.w82[10];
      w7_cur[4] = s_r.w83[5];
   end

   // identify word generator
   // indexed by the transfer word counter, so each read shows the next word
   // word 255 closes the byte sum: csum already holds words 0 to 254 here
   // the sum is ours, not the host's, so a host that skips reads gets a
   // checksum matching only what it was given, and the signature stays fixed
   // words 8 to 254 fall through to zero, serial words included
   always_comb begin
      case (s_r.widx)
         8'd0:    tx_word = `COID_REVISION;
         8'd1:    tx_word = s_r.w63 & `COID_W1_MASK;
         8'd2:    tx_word = s_r.w88 & `COID_W2_MASK;
         8'd3:    tx_word = s_r.maxlba[15:0];
         8'd4:    tx_word = s_r.maxlba[31:16];
         8'd5:    tx_word = s_r.maxlba[47:32];
         8'd6:    tx_word = 16'h0000;
         8'd7:    tx_word = w7_cur;
         8'd255:  tx_word = {8'(-(s_r.csum + `COID_SIGNATURE)), `COID_SIGNATURE};
         default: tx_word = 16'h0000;                           // reserved words
      endcase
   end

   // restriction checks on captured overlay; only clearing matters
   always_comb begin
      bad_bits = 16'h0000;
      bad_word = 8'h00;
      // multiword: bit 0 never clears; keep mode 2 when selected, and mode 1 when mode 2 stays
      if (!s_r.rx_w1[0] || (s_r.w63[2] && s_r.rx_w1[2] && !s_r.rx_w1[1]) ||
          (dma_selected_i[2] && s_r.w63[2] && !s_r.rx_w1[2])) begin
         bad_bits = s_r.w63 & ~s_r.rx_w1 & `COID_W1_MASK;
         bad_word = 8'h01;
      // ultra modes: a selected mode may not be dropped
      // the selected bits sit in the upper byte of the input; widen on purpose
      end else if (|(s_r.w88 & {8'h00, dma_selected_i[15:8]} & ~s_r.rx_w2 & `COID_W2_MASK)) begin
         bad_bits = s_r.w88 & {8'h00, dma_selected_i[15:8]} & ~s_r.rx_w2 & `COID_W2_MASK;
         bad_word = 8'h02;
      // protected area in force: its permission bit may not be withdrawn
      end else if (hpa_established_i && w7_cur[7] && !s_r.rx_w7[7]) begin
         bad_bits = 16'h0080;
         bad_word = 8'h07;
      end
   end

   // single process for bus, command and overlay engine
   // everything but ack defaults to hold; later branches override earlier ones,
   // so the order of the blocks below is the priority between them
   // the task-file writes, the stream and the verdict never fire together: the engine
   // state gates each of them; register reads are ungated and touch only rdata
   always_comb begin
      s_nxt = s_r;
      frz_nxt = frz_r;
      // ack marks the answer cycle; it drops again on the edge that answers
      s_nxt.ack = (avs_read_i | avs_write_i) & ~s_r.ack;   // one wait cycle
      // register reads
      // captured on the first edge of the read, so they stand when waitrequest drops
      // write-only registers (feature, command) read back as zero
      if (rd) begin
         case (avs_address_i)
            `COID_OFS_COUNT:     s_nxt.rdata = {24'h0, s_r.count};
            `COID_OFS_ADDR_LOW:  s_nxt.rdata = {24'h0, s_r.alo};
            `COID_OFS_ADDR_MID:  s_nxt.rdata = {24'h0, s_r.amid};
            `COID_OFS_ADDR_HIGH: s_nxt.rdata = {24'h0, s_r.ahi};
            `COID_OFS_DRIVE:     s_nxt.rdata = {24'h0, s_r.drv};
            `COID_OFS_ERROR:     s_nxt.rdata = {24'h0, s_r.err};
            `COID_OFS_STATE:     s_nxt.rdata = {24'h0, s_r.dst};
            `COID_OFS_DATA:      s_nxt.rdata = {16'h0, tx_word};
            `COID_OFS_CTRL:      s_nxt.rdata = {30'h0, s_r.modified, frz_r};
            `COID_OFS_WORD63:    s_nxt.rdata = {16'h0, s_r.w63};
            `COID_OFS_WORD88:    s_nxt.rdata = {16'h0, s_r.w88};
            `COID_OFS_WORD82:    s_nxt.rdata = {16'h0, s_r.w82};
            `COID_OFS_WORD83:    s_nxt.rdata = {16'h0, s_r.w83};
            `COID_OFS_WORD84:    s_nxt.rdata = {16'h0, s_r.w84};
            `COID_OFS_MAXLBA_LO: s_nxt.rdata = s_r.maxlba[31:0];
            `COID_OFS_MAXLBA_HI: s_nxt.rdata = {16'h0, s_r.maxlba[47:32]};
            default:             s_nxt.rdata = 32'h0;              // unmapped reads zero
         endcase
      end
      // identify data stream: each read of the data word advances
      // reads of the data word outside a transfer return a word but move nothing
      // the last word hands the engine back to idle with the transfer flag down
      if (rd && avs_address_i == `COID_OFS_DATA && s_r.st == COID_SEND) begin
         s_nxt.csum = s_r.csum + tx_word[7:0] + tx_word[15:8];
         s_nxt.widx = s_r.widx + 8'd1;
         if (s_r.widx == `COID_LAST_WORD) begin
            s_nxt.st = COID_IDLE;
            s_nxt.dst = 8'h40;   // ready only
         end
      end
      // task-file writes, ignored while busy
      // only the low byte lane carries a task-file register
      // a command written mid-transfer is dropped rather than restarting the engine,
      // which keeps a half-received overlay from being judged on stale words
      if (wr && avs_byteenable_i[0] && s_r.st == COID_IDLE) begin
         case (avs_address_i)
            `COID_OFS_FEATURE:   s_nxt.feat = avs_writedata_i[7:0];
            `COID_OFS_COUNT:     s_nxt.count = avs_writedata_i[7:0];
            `COID_OFS_ADDR_LOW:  s_nxt.alo = avs_writedata_i[7:0];
            `COID_OFS_ADDR_MID:  s_nxt.amid = avs_writedata_i[7:0];
            `COID_OFS_ADDR_HIGH: s_nxt.ahi = avs_writedata_i[7:0];
            `COID_OFS_DRIVE:     s_nxt.drv = avs_writedata_i[7:0];
            `COID_OFS_COMMAND: begin
               // every command starts from a clean outcome; the address bytes
               // are reused as result registers, so clear them here
               s_nxt.err = 8'h00;
               s_nxt.widx = 8'h00;
               s_nxt.csum = 8'h00;
               s_nxt.alo = 8'h00;
               s_nxt.amid = 8'h00;
               s_nxt.ahi = 8'h00;
               s_nxt.dst = 8'h40;
               if (avs_writedata_i[7:0] != `COID_CMD_OVERLAY || frz_r ||
                   (s_r.feat != `COID_FEAT_SET && s_r.feat != `COID_FEAT_IDENTIFY &&
                    s_r.feat != `COID_FEAT_FREEZE)) begin
                  s_nxt.err[`COID_ERR_ABORT] = 1'b1;
                  s_nxt.dst[`COID_ST_ERR] = 1'b1;
               end else if (s_r.feat == `COID_FEAT_FREEZE) begin
                  // non-data command: completes at once, ready only
                  frz_nxt = 1'b1;
               end else if (s_r.feat == `COID_FEAT_IDENTIFY) begin
                  s_nxt.st = COID_SEND;
                  s_nxt.dst = 8'h48;                                 // ready and xfer request
               end else begin
                  s_nxt.st = COID_RECV;
                  s_nxt.dst = 8'h48;
                  s_nxt.rx_revbad = 1'b0;
                  s_nxt.rx_rsvbad = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // overlay reception, capture only until all 256 words checked
      // nothing reaches the identify words here; the words are only held
      // the sum runs over all 512 bytes, so a correct image ends on zero
      // reserved words are summed but not checked for zero
      if (wr && avs_address_i == `COID_OFS_DATA && s_r.st == COID_RECV) begin
         s_nxt.csum = s_r.csum + rx_word[7:0] + rx_word[15:8];
         s_nxt.widx = s_r.widx + 8'd1;
         case (s_r.widx)
            8'd0: s_nxt.rx_revbad = (rx_word != `COID_REVISION);
            8'd1: s_nxt.rx_w1 = rx_word;
            8'd2: s_nxt.rx_w2 = rx_word;
            8'd3: s_nxt.rx_lba[15:0] = rx_word;
            8'd4: s_nxt.rx_lba[31:16] = rx_word;
            8'd5: s_nxt.rx_lba[47:32] = rx_word;
            8'd7: s_nxt.rx_w7 = rx_word;
            8'd255: s_nxt.rx_rsvbad = (rx_word[7:0] != `COID_SIGNATURE);
            default: ;
         endcase
         if (s_r.widx == `COID_LAST_WORD) begin
            s_nxt.st = COID_DONE;
            s_nxt.dst = 8'h80;   // busy while checking
         end
      end
      // verdict and apply
      // the checks are ordered: revision first, then checksum, then lba, then bits,
      // so the address-high code names the first fault met
      // the abort condition is spelled out again below rather than derived
      // from the code chosen, because a zero code is itself a valid outcome
      // the verdict cycle is the only one with busy up
      if (s_r.st == COID_DONE) begin
         s_nxt.st = COID_IDLE;
         s_nxt.dst = 8'h40;
         s_nxt.drv[`COID_DRV_BIT] = s_r.drv[`COID_DRV_BIT];
         s_nxt.count = 8'h00;                                        // vendor value
         if (s_r.rx_revbad) begin
            s_nxt.ahi = `COID_WORD_REV;
         end else if (s_r.csum != 8'h00 || s_r.rx_rsvbad) begin
            s_nxt.ahi = `COID_WORD_CSUM;
         end else if (s_r.modified || (hpa_established_i && s_r.rx_lba != s_r.maxlba)) begin
            s_nxt.ahi = 8'h00;
            if (!s_r.modified)
               s_nxt.ahi = `COID_WORD_LBA;
         end else if (s_r.rx_lba > s_r.maxlba || s_r.rx_lba == 48'h0) begin
            s_nxt.ahi = `COID_WORD_LBA;
         end else if (bad_word != 8'h00) begin
            s_nxt.alo = bad_bits[7:0];
            s_nxt.amid = bad_bits[15:8];
            s_nxt.ahi = bad_word;
         end
         if (s_r.rx_revbad || s_r.csum != 8'h00 || s_r.rx_rsvbad || s_r.modified ||
             (hpa_established_i && s_r.rx_lba != s_r.maxlba) ||
             s_r.rx_lba > s_r.maxlba || s_r.rx_lba == 48'h0 || bad_word != 8'h00) begin
            s_nxt.err[`COID_ERR_ABORT] = 1'b1;
            s_nxt.dst[`COID_ST_ERR] = 1'b1;
         end else begin
            // only clear bits, never set
            // an accepted overlay locks out a second one until a restore
            s_nxt.modified = 1'b1;
            s_nxt.w63 = s_r.w63 & (s_r.rx_w1 | ~`COID_W1_MASK);
            s_nxt.w88 = s_r.w88 & (s_r.rx_w2 | ~`COID_W2_MASK);
            s_nxt.maxlba = s_r.rx_lba;
            if (!s_r.rx_w7[7]) begin
               s_nxt.w82[10] = 1'b0;
               s_nxt.w83[8] = 1'b0;
            end
            if (!s_r.rx_w7[8])
               s_nxt.w83[10] = 1'b0;
            if (!s_r.rx_w7[4] && !standby_jumper_i)
               s_nxt.w83[6:5] = 2'b00;
            if (!s_r.rx_w7[11])
               s_nxt.w84[7:6] = 2'b00;
            if (!s_r.rx_w7[9])
               s_nxt.w84[4] = 1'b0;
         end
      end
   end

   // state registers; freeze lock only clears on power-on
   // the lock has its own reset so a soft reset cannot reopen the overlay
   // the identify words reload their factory values on rst_i, which
   // stands in for a restore; a real device would keep them in storage
   // hazard: frz_r is unknown until por_i has been seen once
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         frz_r <= 1'b0;
      end else begin
         frz_r <= frz_nxt;
      end
      if (rst_i) begin
         s_r <= '0;
         s_r.st <= COID_IDLE;
         s_r.dst <= 8'h40;
         s_r.w63 <= `COID_DEF_W63;
         s_r.w82 <= `COID_DEF_W82;
         s_r.w83 <= `COID_DEF_W83;
         s_r.w84 <= `COID_DEF_W84;
         s_r.w88 <= `COID_DEF_W88;
         s_r.maxlba <= `COID_DEF_MAXLBA;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// file: verification/coid_properties.sv
`timescale 1ns/1ps
module coid_properties (
   // clock and resets
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  por_i,
   // register bus
   input wire logic [7:0]            avs_address_i,
   input wire logic                  avs_read_i,
   input wire logic                  avs_write_i,
   input wire logic [31:0]           avs_readdata_o,
   input wire logic                  avs_waitrequest_o,
   // engine
   input wire coid_pkg::coid_state_t state_o,
   input wire logic                  freeze_lock_o
);
   import coid_pkg::*;
   // one domain, synchronous reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_WAIT_ONE: assert property (
      ($rose(avs_read_i) || $rose(avs_write_i)) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not one cycle after request");
   AST_ONEHOT: assert property ($onehot(state_o))
      else $error("engine state not one-hot");
   AST_DONE_ONE: assert property (state_o == COID_DONE |=> state_o == COID_IDLE)
      else $error("check state longer than one cycle");
   AST_DONE_FROM_RECV: assert property (state_o == COID_DONE |-> $past(state_o) == COID_RECV)
      else $error("check entered without overlay");
   AST_RECV_CMD: assert property (
      $rose(state_o == COID_RECV) |-> $past(avs_address_i) == 8'h18)
      else $error("overlay receive without command write");
   // lock must ride through rst_i, so only power-on disables it
   AST_FREEZE_HOLD: assert property (@(posedge clk_i) disable iff (por_i)
      freeze_lock_o |=> freeze_lock_o)
      else $error("freeze lock lost without power-on reset");
   AST_FREEZE_POR: assert property ($fell(freeze_lock_o) |-> $past(por_i))
      else $error("freeze lock cleared by other cause");
   AST_UNMAPPED: assert property (
      avs_read_i && !avs_waitrequest_o && avs_address_i > 8'h44 |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind coid_top coid_properties coid_properties_i (
   .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .state_o(state_o), .freeze_lock_o(freeze_lock_o));

// file: verification/coid_host.sv
`timescale 1ns/1ps
module coid_host (
   // clock and answer
   input  wire logic        clk_i,
   input  wire logic        wait_i,
   // request
   output logic [7:0]       addr_o,
   output logic             read_o,
   output logic             write_o,
   output logic [31:0]      wdata_o
);
   logic [63:0] exp_q [$];  // {mask, value} per pending read
   initial begin
      addr_o = 8'h00;
      read_o = 1'b0;
      write_o = 1'b0;
      wdata_o = 32'h0;
   end
   // one bus cycle; held until waitrequest seen low at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      write_o <= w;
      read_o <= !w;
      @(negedge clk_i);
      while (wait_i) @(negedge clk_i);
      @(posedge clk_i);
      write_o <= 1'b0;
      read_o <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      exp_q.push_back({m, v});
      xfer(1'b0, a, 32'h0);
   endtask
   // feature and drive first, command code last
   task automatic cmd(input logic [7:0] feat, input logic [7:0] drv);
      wr(8'h00, {24'h0, feat});
      wr(8'h14, {24'h0, drv});
      wr(8'h18, 32'h0000_00b1);
   endtask
endmodule

// file: verification/coid_top_tb.sv
`timescale 1ns/1ps
`include "coid_map.svh"
module coid_top_tb;
   import coid_pkg::*;
   logic        clk_i, rst_i, por_i, hpa, rd, wr, wreq;
   logic [7:0]  adr, seed, drv;
   logic [31:0] wdat, rdat;
   logic [63:0] e;
   logic [15:0] img [256];   // overlay image
   coid_state_t st;
   logic        frz;
   int          n_fail = 0, samples_checked = 0, cyc = 0;
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   coid_top coid_top_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .standby_jumper_i(1'b0),
      .hpa_established_i(hpa), .dma_selected_i(16'h0000), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .state_o(st), .freeze_lock_o(frz));
   coid_host coid_host_i (.clk_i(clk_i), .wait_i(wreq), .addr_o(adr), .read_o(rd), .write_o(wr),
      .wdata_o(wdat));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input string what, input logic [31:0] x, input logic [31:0] got);
      samples_checked++;
      if (got !== x) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, x, got);
      end
   endtask
   // read results: oldest note against the answered read
   always @(negedge clk_i) begin
      if (rd && !wreq) begin
         e = coid_host_i.exp_q.pop_front();
         check($sformatf("reg %h", adr), e[31:0], rdat & e[63:32]);
      end
   end
   // checksum closes the byte sum to zero; bad flips it
   task automatic seal(input logic [7:0] bad);
      logic [7:0] s;
      s = `COID_SIGNATURE;
      for (int i = 0; i < 255; i++) s += img[i][7:0] + img[i][15:8];
      img[255] = {(-s) ^ bad, `COID_SIGNATURE};
   endtask
   // factory image as the device should report it
   task automatic build();
      for (int i = 0; i < 256; i++) img[i] = 16'h0;
      img[0] = `COID_REVISION;
      img[1] = `COID_DEF_W63 & `COID_W1_MASK;
      img[2] = `COID_DEF_W88 & `COID_W2_MASK;
      {img[5], img[4], img[3]} = `COID_DEF_MAXLBA;
      img[7] = `COID_W7_ALLOWED;
      seal(8'h00);
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 16 && st !== COID_IDLE; k++) @(negedge clk_i);
      check("engine state", 32'(COID_IDLE), 32'(st));
   endtask
   task automatic new_drv();
      seed = lfsr(seed);
      drv = {3'b000, seed[0], 4'h0};  // random drive choice
   endtask
   // overlay set, then task-file outcome
   task automatic set(input logic [7:0] hi, input logic ab);
      new_drv();
      coid_host_i.cmd(`COID_FEAT_SET, drv);
      for (int i = 0; i < 256; i++) coid_host_i.wr(`COID_OFS_DATA, {16'h0, img[i]});
      wait_idle();
      coid_host_i.rd(`COID_OFS_STATE, 32'hff, ab ? 32'h41 : 32'h40);
      coid_host_i.rd(`COID_OFS_ERROR, 32'hff, ab ? 32'h04 : 32'h00);
      coid_host_i.rd(`COID_OFS_DRIVE, 32'h10, {24'h0, drv});
      if (ab) begin
         coid_host_i.rd(`COID_OFS_ADDR_HIGH, 32'hff, {24'h0, hi});
         coid_host_i.rd(`COID_OFS_ADDR_MID, 32'hff, 32'h0);
         coid_host_i.rd(`COID_OFS_ADDR_LOW, 32'hff, 32'h0);
         coid_host_i.rd(`COID_OFS_COUNT, 32'hff, 32'h0);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard, far above the few thousand cycles needed
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("[FAIL] timeout expected finish seen hang");
         summarize();
      end
   end
   initial begin
      rst_i = 1'b1;
      por_i = 1'b1;
      hpa = 1'b0;
      seed = 8'h04;
      drv = 8'h00;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      coid_host_i.rd(`COID_OFS_STATE, 32'hff, 32'h40);
      coid_host_i.rd(8'h80, 32'hffffffff, 32'h0);
      $display("test reset done");
      build();
      new_drv();
      coid_host_i.cmd(`COID_FEAT_IDENTIFY, drv);
      for (int i = 0; i < 256; i++) coid_host_i.rd(`COID_OFS_DATA, 32'hffff, {16'h0, img[i]});
      wait_idle();
      $display("test identify done");
      // revision, checksum, zero address, protected area
      for (int c = 0; c < 4; c++) begin
         build();
         if (c == 0) img[0] = 16'h0003;
         if (c >= 2) img[3] = 16'h0000;
         if (c == 2) {img[5], img[4]} = 32'h0;
         hpa <= (c == 3);
         seal(c == 1 ? 8'h01 : 8'h00);
         set(c == 0 ? 8'h00 : c == 1 ? 8'hff : 8'h03, 1'b1);
      end
      hpa <= 1'b0;
      coid_host_i.rd(`COID_OFS_MAXLBA_LO, 32'hffffffff, `COID_DEF_MAXLBA & 32'hffffffff);
      $display("test aborts done");
      build();
      img[7][4] = 1'b0;
      img[3] = 16'h0000;
      seal(8'h00);
      set(8'h00, 1'b0);
      coid_host_i.rd(`COID_OFS_WORD83, 32'hffff, `COID_DEF_W83 & 32'hff9f);
      coid_host_i.rd(`COID_OFS_MAXLBA_LO, 32'hffffffff, `COID_DEF_MAXLBA & 32'hffff0000);
      set(8'h00, 1'b1);
      $display("test set done");
      new_drv();
      coid_host_i.cmd(`COID_FEAT_FREEZE, drv);
      wait_idle();
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check("freeze after reset", 32'h1, {31'h0, frz});
      coid_host_i.cmd(`COID_FEAT_FREEZE, drv);
      wait_idle();
      coid_host_i.rd(`COID_OFS_ERROR, 32'hff, 32'h04);
      por_i <= 1'b1;
      @(posedge clk_i);
      por_i <= 1'b0;
      @(negedge clk_i);
      check("freeze after power-on", 32'h0, {31'h0, frz});
      $display("test freeze done");
      summarize();
   end
endmodule
